// *** logic/lpp_regs.svh ***
// register offsets, field positions and codes of the leaf permission block
// assumes byte addresses on an 8-bit Avalon-MM address, one 32-bit word per register
`ifndef LPP_REGS_SVH
`define LPP_REGS_SVH
`define LPP_OFF_CTRL       8'h00
`define LPP_OFF_RID_PASID  8'h04
`define LPP_OFF_STATUS     8'h08
`define LPP_OFF_CLEAR      8'h0C
`define LPP_OFF_ENABLE     8'h10
`define LPP_OFF_REC0       8'h20
`define LPP_OFF_REC1       8'h24
`define LPP_OFF_REC2       8'h28
`define LPP_OFF_REC3       8'h2C
`define LPP_CTRL_W         9
`define LPP_CTRL_RST       9'h000
`define LPP_CTRL_EXTENDED_MEMTYPE_ENABLE      0
`define LPP_CTRL_TTM       2:1
`define LPP_CTRL_TRANSLATION_TYPE_SELECT      5:3
`define LPP_CTRL_SECOND_LEVEL_EXEC_ENFORCE      6
`define LPP_CTRL_ZLR       7
`define LPP_CTRL_DT        8
`define LPP_PASID_W        20
`define LPP_STS_W          3
`define LPP_STS_FAULT      0
`define LPP_STS_OVF        1
`define LPP_STS_RSVD_MT    2
`define LPP_LEAF_R         0
`define LPP_LEAF_W         1
`define LPP_LEAF_X         2
`define LPP_LEAF_EMT       5:3
`define LPP_LEAF_SKIP_ATTRIBUTE_TABLE      6
`define LPP_TTM_LEGACY     2'h0
`define LPP_TRANSLATION_TYPE_SELECT_SL_ONLY   3'h2
`define LPP_TRANSLATION_TYPE_SELECT_NESTED    3'h3
`define LPP_FR_READ        8'h01
`define LPP_FR_WRITE       8'h02
`define LPP_FR_EXEC        8'h03
`define LPP_REC_RSVD_HI    127
`define LPP_REC_TYPE       126
`define LPP_REC_AT         125:124
`define LPP_REC_PASID      123:104
`define LPP_REC_FR         103:96
`define LPP_REC_PP         95
`define LPP_REC_EXE        94
`define LPP_REC_PRIV       93
`define LPP_REC_SID        79:64
`define LPP_REC_PAGE       63:12
`define LPP_REC_RSVD_LO    11:0
`endif

// *** logic/lpp_pkg.sv ***
// types shared by the leaf permission block
// assumes nothing beyond a SystemVerilog compiler
package lpp_pkg;
    typedef enum logic [1:0] {
        LPP_BUS_IDLE = 2'h1,
        LPP_BUS_ACK  = 2'h2
    } lpp_bus_state_t;
    typedef enum logic [2:0] {
        LPP_MT_UC = 3'h0,
        LPP_MT_WC = 3'h1,
        LPP_MT_WT = 3'h4,
        LPP_MT_WP = 3'h5,
        LPP_MT_WB = 3'h6
    } lpp_memtype_t;
endpackage

// *** logic/lpp_perm_check.sv ***
// permission and memory-type decode of the low bits of a 4-KByte leaf entry
// assumes the caller registers the results; purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "lpp_regs.svh"
module lpp_perm_check
    import lpp_pkg::*;
(
    input  wire logic       extended_memtype_enable,
    input  wire logic [1:0] translation_table_mode,
    input  wire logic [2:0] translation_type_select,
    input  wire logic       second_level_exec_enforce,
    input  wire logic       zero_length_read_support,
    input  wire logic       req_read,
    input  wire logic       req_write,
    input  wire logic       req_atomic,
    input  wire logic       req_exec,
    input  wire logic       req_zero_len,
    input  wire logic       req_coherent,
    input  wire logic [6:0] leaf,
    output logic            deny_read,
    output logic            deny_write,
    output logic            deny_exec,
    output logic            mt_valid,
    output logic            mt_reserved,
    output logic [2:0]      mt_code,
    output logic            use_pat
);
    function automatic logic mt_known(input logic [2:0] code);
        case (code)
            LPP_MT_UC, LPP_MT_WC, LPP_MT_WT, LPP_MT_WP, LPP_MT_WB: mt_known = 1'b1;
            default: mt_known = 1'b0;
        endcase
    endfunction
    wire emt_on    = extended_memtype_enable && (translation_table_mode != `LPP_TTM_LEGACY);
    wire nested    = translation_type_select == `LPP_TRANSLATION_TYPE_SELECT_NESTED;
    wire sl_only   = translation_type_select == `LPP_TRANSLATION_TYPE_SELECT_SL_ONLY;
    wire rd_like   = req_read || req_atomic;
    wire wr_like   = req_write || req_atomic;
    // RQ8: zero-length read bypass
    wire zlr_skip  = zero_length_read_support && req_zero_len && req_read && !wr_like
                     && (leaf[`LPP_LEAF_X] || leaf[`LPP_LEAF_W]);
    // RQ7: read permission
    assign deny_read   = rd_like && !leaf[`LPP_LEAF_R] && !zlr_skip;
    // RQ6: write permission
    assign deny_write  = wr_like && !leaf[`LPP_LEAF_W];
    // RQ5: execute enforcement
    assign deny_exec   = second_level_exec_enforce && req_exec && !leaf[`LPP_LEAF_X];
    // RQ3: memory type usage
    assign mt_valid    = emt_on && req_coherent && (nested || sl_only);
    assign mt_code     = leaf[`LPP_LEAF_EMT];
    // RQ4: reserved memory-type codes
    assign mt_reserved = !mt_known(mt_code);
    // RQ1: skip flag applicability
    // RQ2: skip flag drops the table
    assign use_pat     = !(emt_on && nested && req_coherent && leaf[`LPP_LEAF_SKIP_ATTRIBUTE_TABLE]);
endmodule
`default_nettype wire

// *** logic/lpp_fault_enc.sv ***
// packs one non-recoverable translation fault into the 128-bit record
// assumes inputs are those of the blocked request, taken in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "lpp_regs.svh"
module lpp_fault_enc (
    input  wire logic        type_read,
    input  wire logic [1:0]  addr_type,
    input  wire logic        device_tlb_support,
    input  wire logic        pasid_valid,
    input  wire logic [19:0] pasid,
    input  wire logic        legacy_mode,
    input  wire logic [19:0] rid_pasid,
    input  wire logic [7:0]  fault_reason_code,
    input  wire logic        exec_req,
    input  wire logic        priv_req,
    input  wire logic [15:0] faulted_requester,
    input  wire logic [51:0] fault_info,
    output logic [127:0]     record
);
    logic [19:0] faulted_space_id;
    // RQ12: space id source
    assign faulted_space_id = pasid_valid ? pasid : (legacy_mode ? 20'h00000 : rid_pasid);
    always_comb begin
        // RQ17: reserved bits stay zero
        record                   = 128'h0;
        // RQ9: type bit
        record[`LPP_REC_TYPE]    = type_read;
        // RQ10: address type copy
        // RQ11: zero without device-side cache
        record[`LPP_REC_AT]      = device_tlb_support ? addr_type : 2'h0;
        record[`LPP_REC_PASID]   = faulted_space_id;
        // RQ13: reason code
        record[`LPP_REC_FR]      = fault_reason_code;
        record[`LPP_REC_PP]      = pasid_valid;
        record[`LPP_REC_EXE]     = pasid_valid && type_read && exec_req;
        record[`LPP_REC_PRIV]    = pasid_valid && priv_req;
        // RQ14: requester id
        record[`LPP_REC_SID]     = faulted_requester;
        // RQ15: page address
        record[`LPP_REC_PAGE]    = fault_info;
    end
endmodule
`default_nettype wire

// *** logic/lpp_top.sv ***
// leaf page permission check with fault record, Avalon-MM register slave and interrupt
// assumes one 100 MHz clock, requests synchronous to it, one request per cycle at most
//
// Notes on behaviour
// RQ1: the skip-table flag counts only for nested setups from coherent devices with memory typing on and non-legacy mode.
// RQ2: skip-table flag 0 keeps the context page attribute table in the memory type, 1 drops it.
// RQ3: with memory typing on, bits 5:3 give the memory type for second-level-only and nested coherent requests.
// RQ4: memory type codes 0,1,4,5,6 are known and every other code is reserved.
// RQ5: with execute enforcement on, a clear execute bit denies execute requests.
// RQ6: a clear write bit denies writes to the page.
// RQ7: a clear read bit denies reads to the page.
// RQ8: with zero-length-read support, a zero-length read skips the read check if execute or write is set.
// RQ9: record bit 126 is 0 for writes and 1 for reads or atomics.
// RQ10: record bits 125:124 copy the request address type.
// RQ11: without device-side translation caching the address type field is written as zero.
// RQ12: record bits 123:104 carry the request space id when it has one.
// RQ13: record bits 103:96 hold the fault reason code.
// RQ14: record bits 79:64 hold the requester id.
// RQ15: record bits 63:12 hold the page address of the request.
// RQ16: a request failing any check is blocked and produces a fault record; the code records only while the fault status bit is clear.
// RQ17: record bit 127 and bits 11:0 are zero and leaf bit 7 is never looked at.
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lpp_regs.svh"
module lpp_top
    import lpp_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        req_valid,
    input  wire logic        req_read,
    input  wire logic        req_write,
    input  wire logic        req_atomic,
    input  wire logic        req_exec,
    input  wire logic        req_priv,
    input  wire logic        req_zero_len,
    input  wire logic        req_coherent,
    input  wire logic [1:0]  req_addr_type,
    input  wire logic        req_pasid_valid,
    input  wire logic [19:0] req_pasid,
    input  wire logic [15:0] req_requester,
    input  wire logic [51:0] req_page,
    input  wire logic [7:0]  second_level_leaf_entry,
    output logic             resp_valid,
    output logic             resp_blocked,
    output logic [2:0]       resp_memtype,
    output logic             resp_memtype_valid,
    output logic             resp_memtype_rsvd,
    output logic             resp_use_pat,
    output logic             irq
);
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        be_merge = (old_v & ~m) | (new_v & m);
    endfunction

    // reset release through two flops
    logic rst_meta_n;
    logic rst_sync_n;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // software state
    logic [`LPP_CTRL_W-1:0]  ctrl;
    logic [`LPP_PASID_W-1:0] rid_pasid;
    logic [`LPP_STS_W-1:0]   status;
    logic [`LPP_STS_W-1:0]   enable;
    logic [127:0]            record;
    lpp_bus_state_t          bus_state;
    lpp_bus_state_t          next_bus_state;

    wire                    extended_memtype_enable   = ctrl[`LPP_CTRL_EXTENDED_MEMTYPE_ENABLE];
    wire [1:0]              translation_table_mode    = ctrl[`LPP_CTRL_TTM];
    wire [2:0]              translation_type_select   = ctrl[`LPP_CTRL_TRANSLATION_TYPE_SELECT];
    wire                    second_level_exec_enforce = ctrl[`LPP_CTRL_SECOND_LEVEL_EXEC_ENFORCE];
    wire                    zero_length_read_support  = ctrl[`LPP_CTRL_ZLR];
    wire                    device_tlb_support        = ctrl[`LPP_CTRL_DT];

    // bus handshake: one wait cycle, then the access completes
    wire                    bus_req  = avs_read || avs_write;
    wire                    bus_done = (bus_state == LPP_BUS_ACK) && bus_req;
    wire                    wr_en    = bus_done && avs_write;
    wire                    rd_take  = (bus_state == LPP_BUS_IDLE) && avs_read;
    wire                    sel_ctrl  = avs_address == `LPP_OFF_CTRL;
    wire                    sel_rpid  = avs_address == `LPP_OFF_RID_PASID;
    wire                    sel_sts   = avs_address == `LPP_OFF_STATUS;
    wire                    sel_clr   = avs_address == `LPP_OFF_CLEAR;
    wire                    sel_en    = avs_address == `LPP_OFF_ENABLE;
    wire                    sel_rec0  = avs_address == `LPP_OFF_REC0;
    wire                    sel_rec1  = avs_address == `LPP_OFF_REC1;
    wire                    sel_rec2  = avs_address == `LPP_OFF_REC2;
    wire                    sel_rec3  = avs_address == `LPP_OFF_REC3;

    always_comb begin
        case (bus_state)
            LPP_BUS_IDLE: next_bus_state = bus_req ? LPP_BUS_ACK : LPP_BUS_IDLE;
            LPP_BUS_ACK:  next_bus_state = LPP_BUS_IDLE;
            default:      next_bus_state = LPP_BUS_IDLE;
        endcase
    end

    // unmapped and write-only addresses read as zero
    wire [31:0] rd_mux =
        sel_ctrl ? {{(32-`LPP_CTRL_W){1'b0}}, ctrl} :
        sel_rpid ? {{(32-`LPP_PASID_W){1'b0}}, rid_pasid} :
        sel_sts  ? {{(32-`LPP_STS_W){1'b0}}, status} :
        sel_en   ? {{(32-`LPP_STS_W){1'b0}}, enable} :
        sel_rec0 ? record[31:0] :
        sel_rec1 ? record[63:32] :
        sel_rec2 ? record[95:64] :
        sel_rec3 ? record[127:96] : 32'h0;

    wire [31:0] ctrl_wr = be_merge({{(32-`LPP_CTRL_W){1'b0}}, ctrl}, avs_writedata,
                                   avs_byteenable);
    wire [31:0] rpid_wr = be_merge({{(32-`LPP_PASID_W){1'b0}}, rid_pasid}, avs_writedata,
                                   avs_byteenable);
    wire [31:0] en_wr   = be_merge({{(32-`LPP_STS_W){1'b0}}, enable}, avs_writedata,
                                   avs_byteenable);
    wire [`LPP_STS_W-1:0] clr_mask = (wr_en && sel_clr && avs_byteenable[0]) ?
                                     avs_writedata[`LPP_STS_W-1:0] : {`LPP_STS_W{1'b0}};

    // request check
    logic       deny_read;
    logic       deny_write;
    logic       deny_exec;
    logic       mt_valid;
    logic       mt_reserved;
    logic [2:0] mt_code;
    logic       use_pat;
    logic [127:0] new_record;

    // RQ17: bit 7 of the entry is left unconnected on purpose
    lpp_perm_check u_check (
        .extended_memtype_enable   (extended_memtype_enable),
        .translation_table_mode    (translation_table_mode),
        .translation_type_select   (translation_type_select),
        .second_level_exec_enforce (second_level_exec_enforce),
        .zero_length_read_support  (zero_length_read_support),
        .req_read                  (req_read),
        .req_write                 (req_write),
        .req_atomic                (req_atomic),
        .req_exec                  (req_exec),
        .req_zero_len              (req_zero_len),
        .req_coherent              (req_coherent),
        .leaf                      (second_level_leaf_entry[6:0]),
        .deny_read                 (deny_read),
        .deny_write                (deny_write),
        .deny_exec                 (deny_exec),
        .mt_valid                  (mt_valid),
        .mt_reserved               (mt_reserved),
        .mt_code                   (mt_code),
        .use_pat                   (use_pat)
    );

    // write denial is reported first, then read, then execute
    wire [7:0] fault_reason_code = deny_write ? `LPP_FR_WRITE :
                                   deny_read  ? `LPP_FR_READ  : `LPP_FR_EXEC;

    lpp_fault_enc u_enc (
        .type_read          (!req_write),
        .addr_type          (req_addr_type),
        .device_tlb_support (device_tlb_support),
        .pasid_valid        (req_pasid_valid),
        .pasid              (req_pasid),
        .legacy_mode        (translation_table_mode == `LPP_TTM_LEGACY),
        .rid_pasid          (rid_pasid),
        .fault_reason_code  (fault_reason_code),
        .exec_req           (req_exec),
        .priv_req           (req_priv),
        .faulted_requester  (req_requester),
        .fault_info         (req_page),
        .record             (new_record)
    );

    // RQ16: any denial blocks and logs
    wire fault_hit = req_valid && (deny_read || deny_write || deny_exec);
    // first fault is kept until software clears it; later ones only flag overflow
    wire rec_take  = fault_hit && !status[`LPP_STS_FAULT];
    wire [`LPP_STS_W-1:0] events;
    assign events[`LPP_STS_FAULT]   = fault_hit;
    assign events[`LPP_STS_OVF]     = fault_hit && status[`LPP_STS_FAULT];
    assign events[`LPP_STS_RSVD_MT] = req_valid && mt_valid && mt_reserved;
    // a new event wins over a clear in the same cycle
    wire [`LPP_STS_W-1:0] next_status = (status & ~clr_mask) | events;
    wire [`LPP_STS_W-1:0] next_enable = (wr_en && sel_en) ? en_wr[`LPP_STS_W-1:0] : enable;

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bus_state       <= LPP_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            bus_state       <= next_bus_state;
            avs_waitrequest <= next_bus_state != LPP_BUS_ACK;
            if (rd_take) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl      <= `LPP_CTRL_RST;
            rid_pasid <= {`LPP_PASID_W{1'b0}};
            enable    <= {`LPP_STS_W{1'b0}};
            status    <= {`LPP_STS_W{1'b0}};
            irq       <= 1'b0;
        end else begin
            if (wr_en && sel_ctrl) begin
                ctrl <= ctrl_wr[`LPP_CTRL_W-1:0];
            end
            if (wr_en && sel_rpid) begin
                rid_pasid <= rpid_wr[`LPP_PASID_W-1:0];
            end
            enable <= next_enable;
            status <= next_status;
            irq    <= |(next_status & next_enable);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            record <= 128'h0;
        end else if (rec_take) begin
            record <= new_record;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            resp_valid         <= 1'b0;
            resp_blocked       <= 1'b0;
            resp_memtype       <= 3'h0;
            resp_memtype_valid <= 1'b0;
            resp_memtype_rsvd  <= 1'b0;
            resp_use_pat       <= 1'b1;
        end else begin
            resp_valid <= req_valid;
            if (req_valid) begin
                resp_blocked       <= fault_hit;
                resp_memtype       <= mt_valid ? mt_code : 3'h0;
                resp_memtype_valid <= mt_valid;
                resp_memtype_rsvd  <= mt_valid && mt_reserved;
                resp_use_pat       <= use_pat;
            end
        end
    end

    default clocking ast_clk @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_n);

    AST_WAIT_ONE: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest not released after one cycle");
    AST_BLOCK_ANY: assert property (req_valid |=> resp_valid && resp_blocked == $past(fault_hit)) // RQ16
        else $error("block result does not follow the checks");
    AST_WRITE_DENY: assert property (req_valid && req_write && !second_level_leaf_entry[1] // RQ6
                                     |=> resp_blocked)
        else $error("write to non-writable page not blocked");
    AST_READ_DENY: assert property (req_valid && req_read && !req_zero_len // RQ7
                                    && !second_level_leaf_entry[0] |=> resp_blocked)
        else $error("read of non-readable page not blocked");
    AST_ZLR_SKIP: assert property (req_valid && req_read && !req_write && !req_atomic // RQ8
                                   && !req_exec && req_zero_len && zero_length_read_support
                                   && (second_level_leaf_entry[1] || second_level_leaf_entry[2])
                                   |=> !resp_blocked)
        else $error("zero-length read blocked by read check");
    AST_EXEC_DENY: assert property (req_valid && req_exec && second_level_exec_enforce // RQ5
                                    && !second_level_leaf_entry[2] |=> resp_blocked)
        else $error("execute on non-executable page not blocked");
    AST_MT_OFF: assert property (req_valid && (!extended_memtype_enable // RQ3
                                 || translation_table_mode == `LPP_TTM_LEGACY)
                                 |=> !resp_memtype_valid && resp_use_pat)
        else $error("memory type used while extended typing is off");
    AST_SKIP_PAT: assert property (req_valid && mt_valid && translation_type_select // RQ2
                                   == `LPP_TRANSLATION_TYPE_SELECT_NESTED |=> resp_use_pat
                                   == !$past(second_level_leaf_entry[6]))
        else $error("skip flag not applied to nested request");
    AST_REC_TYPE: assert property (rec_take |=> record[126] == !$past(req_write)) // RQ9
        else $error("record type bit wrong");
    AST_REC_AT: assert property (rec_take && !device_tlb_support |=> record[125:124] == 2'h0) // RQ11
        else $error("address type not zero without device cache");
    AST_REC_ZERO: assert property (record[127] == 1'b0 && record[11:0] == 12'h0) // RQ17
        else $error("reserved record bits not zero");
    AST_REC_SID: assert property (rec_take |=> record[79:64] == $past(req_requester) // RQ14
                                  && record[63:12] == $past(req_page))
        else $error("requester or page not recorded");
    AST_IRQ_LEVEL: assert property (irq == |(status & enable))
        else $error("interrupt does not match enabled status");

    COV_FAULT: cover property (rec_take ##1 irq);
    COV_OVERFLOW: cover property (fault_hit && status[`LPP_STS_FAULT]);
    COV_ZLR: cover property (req_valid && req_zero_len && zero_length_read_support
                             && !second_level_leaf_entry[0] ##1 !resp_blocked);
    COV_RSVD_MT: cover property (events[`LPP_STS_RSVD_MT]);
endmodule
`default_nettype wire

// *** tb/lpp_dma_src.sv ***
// request source standing in for the dma device
// assumes the block's sys_clk; the access kind is packed read,write,atomic,exec,zero-length
`timescale 1ns/1ps
`default_nettype none
module lpp_dma_src (
    input  wire logic  sys_clk,
    output logic       req_valid,
    output logic [4:0] kind,
    output logic [7:0] leaf
);
    initial {req_valid, kind, leaf} = '0;
    task automatic send(input logic [4:0] k, input logic [7:0] e);
        @(posedge sys_clk);
        {req_valid, kind, leaf} <= {1'b1, k, e};
        @(posedge sys_clk);
        // inverse while idle, so a late sample of stale fields cannot look right
        {req_valid, kind, leaf} <= {1'b0, ~k, ~e};
    endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// bench top: register bus, fault record, zero-length and memory type scenarios
// assumes the lpp_top map and an answer one cycle after each request
`timescale 1ns/1ps
`default_nettype none
`include "lpp_regs.svh"
module tb_top;
    localparam logic [51:0] pg = 52'hFEDCBA9876543;
    logic        sys_clk, rst_n, rd, wr, wait_rq, irq, vld, priv, coh, pv, rv, blk, mv, mr, up;
    logic [1:0]  at;
    logic [2:0]  mt;
    logic [3:0]  be;
    logic [4:0]  kind;
    logic [7:0]  addr, leaf;
    logic [19:0] pasid;
    logic [31:0] wd, rdata, q;
    int          failures = 0, checks_done = 0, cyc = 0;
    lpp_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wait_rq), .req_valid(vld), .req_read(kind[4]), .req_write(kind[3]),
        .req_atomic(kind[2]), .req_exec(kind[1]), .req_zero_len(kind[0]), .req_priv(priv),
        .req_coherent(coh), .req_addr_type(at), .req_pasid_valid(pv), .req_pasid(pasid),
        .req_requester(16'h1234), .req_page(pg), .second_level_leaf_entry(leaf),
        .resp_valid(rv), .resp_blocked(blk), .resp_memtype(mt), .resp_memtype_valid(mv),
        .resp_memtype_rsvd(mr), .resp_use_pat(up), .irq(irq));
    lpp_dma_src u_src (.sys_clk(sys_clk), .req_valid(vld), .kind(kind), .leaf(leaf));
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {addr, wr, rd, wd} <= {a, w, !w, d};
        // waitrequest and readdata are taken at the one edge that sees waitrequest low
        do begin
            @(posedge sys_clk);
        end while (wait_rq !== 1'b0);
        q = rdata;
        {rd, wr} <= 2'h0;
    endtask
    task automatic rq(input logic [4:0] k, input logic [7:0] e, input logic b);
        u_src.send(k, e);
        #1;
        chk("resp_valid", 1, rv);
        chk("resp_blocked", b, blk);
    endtask
    // record words low first, then the whole status is cleared
    task automatic rec(input logic [63:0] e);
        for (int i = 0; i < 4; i++) begin
            bus(0, 8'(32 + 4 * i), 0);
            chk("record", {e, pg, 12'h0} >> (32 * i), q);
        end
        bus(1, `LPP_OFF_CLEAR, 32'h7);
    endtask
    task automatic t_write_fault;
        @(posedge sys_clk);
        {priv, pv, at, pasid} <= {2'h3, 2'h2, 20'hABCDE};
        bus(1, `LPP_OFF_CTRL, 32'h102);
        bus(1, `LPP_OFF_ENABLE, 32'h1);
        rq(5'h08, 8'h85, 1);
        chk("irq", 1, irq);
        rec({4'h2, 20'hABCDE, 8'h02, 3'h5, 29'h1234});
        $display("write_fault done");
    endtask
    task automatic t_read_fault;
        @(posedge sys_clk);
        {priv, pv, at} <= 4'h1;
        bus(1, `LPP_OFF_CTRL, 32'h042);
        bus(1, `LPP_OFF_ENABLE, 32'h0);
        rq(5'h12, 8'h06, 1);
        bus(0, `LPP_OFF_STATUS, 0);
        chk("status", 1, q);
        chk("irq", 0, irq);
        rec({4'h4, 20'h0, 8'h01, 3'h0, 29'h1234});
        rq(5'h12, 8'h05, 0);
        rq(5'h12, 8'h01, 1);
        rec({4'h4, 20'h0, 8'h03, 3'h0, 29'h1234});
        $display("read_fault done");
    endtask
    task automatic t_zero_len;
        bus(1, `LPP_OFF_CTRL, 32'h080);
        rq(5'h11, 8'h02, 0);
        rq(5'h11, 8'h00, 1);
        bus(1, `LPP_OFF_CTRL, 32'h000);
        rq(5'h11, 8'h04, 1);
        bus(0, `LPP_OFF_STATUS, 0);
        chk("status_ovf", 3, q);
        bus(1, `LPP_OFF_CLEAR, 32'h7);
        $display("zero_len done");
    endtask
    task automatic t_memtype;
        logic [2:0] m;
        @(posedge sys_clk);
        coh <= 1'b1;
        bus(1, `LPP_OFF_CTRL, 32'h01B);
        for (int c = 0; c < 8; c++) begin
            m = 3'(c);
            rq(5'h10, {1'b1, m[0], m, 3'h1}, 0);
            chk("memtype", {m, 1'b1, m == 2 || m == 3 || m == 7, !m[0]}, {mt, mv, mr, up});
        end
        bus(1, `LPP_OFF_CTRL, 32'h019);
        rq(5'h10, 8'hC9, 0);
        chk("memtype_off", 1, {mv, up});
        $display("memtype done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        {rst_n, rd, wr, addr, wd, priv, coh, pv, at, pasid} = '0;
        be = 4'hF;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("use_pat", 1, up);
        bus(0, 8'h40, 0);
        chk("unmapped", 0, q);
        t_write_fault();
        t_read_fault();
        t_zero_len();
        t_memtype();
        tally_and_finish();
    end
endmodule
`default_nettype wire
